// [common/usbep_pkg.sv]
// shared constants and types for the low-speed endpoint register block
package usbep_pkg;
  localparam int USBEP_AW = 8;
  localparam logic [7:0] USBEP_OFF_ADDR = 8'h10;
  localparam logic [7:0] USBEP_OFF_CNT0 = 8'h11;
  localparam logic [7:0] USBEP_OFF_MODE0 = 8'h12;
  localparam logic [7:0] USBEP_OFF_CNT1 = 8'h13;
  localparam logic [7:0] USBEP_OFF_MODE1 = 8'h14;
  localparam logic [7:0] USBEP_OFF_CNT2 = 8'h15;
  localparam logic [7:0] USBEP_OFF_MODE2 = 8'h16;
  // endpoint buffers: ep0 at E0..E7, ep1 at F0..F7, ep2 at F8..FF
  localparam logic [7:0] USBEP_BUF0_BASE = 8'hE0;
  localparam logic [7:0] USBEP_BUF1_BASE = 8'hF0;
  localparam logic [7:0] USBEP_BUF2_BASE = 8'hF8;
  localparam int USBEP_BUF_BYTES = 8;
  // field positions
  localparam int USBEP_ADDR_EN_BIT = 7;
  localparam int USBEP_SETUP_BIT = 7;
  localparam int USBEP_IN_BIT = 6;
  localparam int USBEP_OUT_BIT = 5;
  localparam int USBEP_ACK_BIT = 4;
  localparam int USBEP_VALID_BIT = 6;
  localparam int USBEP_TOGGLE_BIT = 7;
  localparam logic [7:0] USBEP_RESET_VAL = 8'h00;
  localparam logic [3:0] USBEP_MAX_COUNT = 4'h8;
  // bus reset timing
  localparam int USBEP_CLK_HZ = 40000000;
  localparam int USBEP_BUS_RESET_NS = 8000;
  localparam int USBEP_BUS_RESET_CYC =
    (USBEP_BUS_RESET_NS * (USBEP_CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [1:0] {
    USBEP_TOK_SETUP,
    USBEP_TOK_IN,
    USBEP_TOK_OUT
  } usbep_tok_t;
endpackage

// [common/usbep_eng_if.sv]
// serial engine to register file carrier
interface usbep_eng_if;
  import usbep_pkg::*;
  logic setup_data;
  logic done;
  usbep_tok_t tok;
  logic [1:0] ep;
  logic acked;
  logic valid;
  logic toggle;
  logic [7:0] mode0;
  modport eng (output setup_data, done, tok, ep, acked, valid, toggle,
    input mode0);
  modport regs (input setup_data, done, tok, ep, acked, valid, toggle,
    output mode0);
endinterface

// [rtl/usbep_bus_reset.sv]
// single-ended zero timer that flags a usb bus reset
module usbep_bus_reset #(
  parameter int CYCLES = usbep_pkg::USBEP_BUS_RESET_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // synchronised line levels
  input wire logic dp,
  input wire logic dm,
  // one-cycle detection pulse
  output logic bus_reset
);
  import usbep_pkg::*;
  logic [15:0] se0_cnt_reg;
  logic se0;
  assign se0 = !dp && !dm;
  // counts past the limit so the pulse fires once per long se0
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      se0_cnt_reg <= 16'h0000;
    end else if (!se0) begin
      se0_cnt_reg <= 16'h0000;
    end else if (se0_cnt_reg <= 16'(CYCLES)) begin
      se0_cnt_reg <= se0_cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= se0 && (se0_cnt_reg == 16'(CYCLES));
    end
  end
endmodule

// [rtl/usbep_regs.sv]
// endpoint register file, buffers and address logic of the usb function
// What this block does
// - reset clears the device address register, disabling the address.
// - traffic to our address is ignored until the enable bit is set.
// - hardware reset and usb bus reset both clear the address register.
// - each of three endpoints owns an eight-byte buffer.
// - endpoint 0 both receives and transmits, including setup packets.
// - all endpoint mode registers reset to zero.
// - endpoint 0 bits 7:5 are token flags; each ep0 update sets its token's bit and clears the other two, except the setup bit while the setup flag is held.
// - endpoints 1 and 2 have no token flags in bits 7:5.
// - acknowledge flag set when a transaction ends with ack.
// - setup flag held from setup data until the ep0 transaction ends, then until first read.
// - after an ep0 engine update, cpu writes to mode0 bits 7:0 blocked until a mode0 read.
// - setup flag blocks cpu writes to E0..E7 and F8..FF.
// - mode bits 3:0 select how the endpoint answers traffic.
// - count low bits give in-packet length 0 to 8, sent exactly.
// - data valid bit applies only to out and setup data.
// - count bit 7 is the data toggle, 0 data0 and 1 data1.
// - se0 longer than 8 us is a bus reset; it clears the address.
module usbep_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // cpu io port
  input wire logic [7:0] io_addr,
  input wire logic io_read_op,
  input wire logic io_write_op,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // usb line levels from the transceiver
  input wire logic dp_pin,
  input wire logic dm_pin,
  // serial engine status strobes
  input wire logic eng_setup_data,
  input wire logic eng_done,
  input wire usbep_pkg::usbep_tok_t eng_tok,
  input wire logic [1:0] eng_ep,
  input wire logic eng_acked,
  input wire logic eng_valid,
  input wire logic eng_toggle,
  input wire logic [7:0] token_addr,
  // serial engine buffer port
  input wire logic eng_buf_we,
  input wire logic [4:0] eng_buf_idx,
  input wire logic [7:0] eng_buf_wdata,
  output logic [7:0] eng_buf_rdata,
  // decoded endpoint settings for the engine
  output logic addr_match,
  output logic [3:0] ep0_mode,
  output logic [3:0] ep1_mode,
  output logic [3:0] ep2_mode,
  output logic [3:0] ep0_tx_count,
  output logic [3:0] ep1_tx_count,
  output logic [3:0] ep2_tx_count,
  output logic usb_bus_reset
);
  import usbep_pkg::*;

  usbep_eng_if eng ();
  assign eng.setup_data = eng_setup_data;
  assign eng.done = eng_done;
  assign eng.tok = eng_tok;
  assign eng.ep = eng_ep;
  assign eng.acked = eng_acked;
  assign eng.valid = eng_valid;
  assign eng.toggle = eng_toggle;

  // line synchronisers
  logic [1:0] dp_sync_reg;
  logic [1:0] dm_sync_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // reset to the low-speed idle levels so no false se0 follows reset
      dp_sync_reg <= 2'h0;
      dm_sync_reg <= 2'h3;
    end else begin
      dp_sync_reg <= {dp_sync_reg[0], dp_pin};
      dm_sync_reg <= {dm_sync_reg[0], dm_pin};
    end
  end

  logic bus_reset;
  usbep_bus_reset u_bus_reset (
    .mclk(mclk),
    .reset_n(reset_n),
    .dp(dp_sync_reg[1]),
    .dm(dm_sync_reg[1]),
    .bus_reset(bus_reset)
  );

  function automatic logic is_buf(input logic [7:0] a);
    return a >= USBEP_BUF0_BASE &&
      (a < USBEP_BUF0_BASE + 8'(USBEP_BUF_BYTES) || a >= USBEP_BUF1_BASE);
  endfunction

  function automatic logic [4:0] buf_index(input logic [7:0] a);
    // ep0 -> 0..7, ep1 -> 8..15, ep2 -> 16..23
    if (a < USBEP_BUF1_BASE) begin
      return {2'b00, a[2:0]};
    end else if (a < USBEP_BUF2_BASE) begin
      return {2'b01, a[2:0]};
    end
    return {2'b10, a[2:0]};
  endfunction

  logic wr_addr, wr_mode0, rd_mode0;
  assign wr_addr = io_write_op && io_addr == USBEP_OFF_ADDR;
  assign wr_mode0 = io_write_op && io_addr == USBEP_OFF_MODE0;
  assign rd_mode0 = io_read_op && io_addr == USBEP_OFF_MODE0;

  // device address
  logic [7:0] func_addr_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      func_addr_reg <= USBEP_RESET_VAL;
    end else if (bus_reset) begin
      func_addr_reg <= USBEP_RESET_VAL;
    end else if (wr_addr) begin
      func_addr_reg <= io_wdata;
    end
  end

  // address compare: engine treats our address as absent until enabled
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_match <= 1'b0;
    end else begin
      addr_match <= func_addr_reg[USBEP_ADDR_EN_BIT] &&
        token_addr[6:0] == func_addr_reg[6:0];
    end
  end

  // endpoint 0 mode/status with lock logic
  logic [7:0] mode0_reg;
  logic lock0_reg;
  logic setup_hold_reg;
  logic setup_pin_reg;
  logic eng_upd0;
  assign eng_upd0 = eng.done && eng.ep == 2'd0;

  // setup flag: forced during data phase, pinned until first read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      setup_hold_reg <= 1'b0;
    end else if (eng.setup_data) begin
      setup_hold_reg <= 1'b1;
    end else if (eng_upd0 || bus_reset) begin
      setup_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      setup_pin_reg <= 1'b0;
    end else if (eng.setup_data) begin
      setup_pin_reg <= 1'b1;
    end else if (rd_mode0 && !setup_hold_reg) begin
      setup_pin_reg <= 1'b0;
    end
  end

  // engine update wins over a read in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock0_reg <= 1'b0;
    end else if (eng_upd0) begin
      lock0_reg <= 1'b1;
    end else if (rd_mode0) begin
      lock0_reg <= 1'b0;
    end
  end

  logic [7:0] mode0_next;
  always_comb begin
    mode0_next = mode0_reg;
    if (wr_mode0 && !lock0_reg && !eng_upd0) begin
      mode0_next = io_wdata;
    end
    if (eng_upd0) begin
      mode0_next[USBEP_SETUP_BIT] = eng.tok == USBEP_TOK_SETUP;
      mode0_next[USBEP_IN_BIT] = eng.tok == USBEP_TOK_IN;
      mode0_next[USBEP_OUT_BIT] = eng.tok == USBEP_TOK_OUT;
      mode0_next[USBEP_ACK_BIT] = eng.acked;
    end
    if (setup_hold_reg || setup_pin_reg || eng.setup_data) begin
      mode0_next[USBEP_SETUP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode0_reg <= USBEP_RESET_VAL;
    end else begin
      mode0_reg <= mode0_next;
    end
  end
  assign eng.mode0 = mode0_reg;

  // endpoints 1 and 2 mode registers and all count registers
  logic [7:0] mode_reg [1:2];
  logic [7:0] cnt_reg [0:2];
  genvar g;
  generate
    for (g = 1; g <= 2; g++) begin : g_mode
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          mode_reg[g] <= USBEP_RESET_VAL;
        end else if (eng.done && eng.ep == 2'(g) && eng.acked) begin
          mode_reg[g][USBEP_ACK_BIT] <= 1'b1;
        end else if (io_write_op &&
            io_addr == USBEP_OFF_CNT0 + 8'(2 * g + 1)) begin
          mode_reg[g] <= {3'b000, io_wdata[4:0]};
        end
      end
    end
    for (g = 0; g <= 2; g++) begin : g_cnt
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_reg[g] <= USBEP_RESET_VAL;
        end else if (eng.done && eng.ep == 2'(g) &&
            eng.tok != USBEP_TOK_IN) begin
          // received data reports valid and toggle
          cnt_reg[g][USBEP_VALID_BIT] <= eng.valid;
          cnt_reg[g][USBEP_TOGGLE_BIT] <= eng.toggle;
        end else if (io_write_op &&
            io_addr == USBEP_OFF_CNT0 + 8'(2 * g)) begin
          cnt_reg[g] <= io_wdata;
        end
      end
    end
  endgenerate

  // clamp so the engine never sends past the eight-byte buffer
  function automatic logic [3:0] tx_len(input logic [7:0] c);
    return (c[3:0] > USBEP_MAX_COUNT) ? USBEP_MAX_COUNT : c[3:0];
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ep0_mode <= 4'h0;
      ep1_mode <= 4'h0;
      ep2_mode <= 4'h0;
      ep0_tx_count <= 4'h0;
      ep1_tx_count <= 4'h0;
      ep2_tx_count <= 4'h0;
    end else begin
      ep0_mode <= mode0_reg[3:0];
      ep1_mode <= mode_reg[1][3:0];
      ep2_mode <= mode_reg[2][3:0];
      ep0_tx_count <= tx_len(cnt_reg[0]);
      ep1_tx_count <= tx_len(cnt_reg[1]);
      ep2_tx_count <= tx_len(cnt_reg[2]);
    end
  end

  // endpoint buffers, 3 x 8 bytes
  logic [7:0] buf_mem [0:3*USBEP_BUF_BYTES-1];
  logic cpu_buf_we;
  logic [4:0] cpu_idx;
  logic setup_lock;
  assign setup_lock = mode0_reg[USBEP_SETUP_BIT];
  assign cpu_idx = buf_index(io_addr);
  // ep1 buffer stays writable; only ep0 and ep2 ranges are guarded
  assign cpu_buf_we = io_write_op && is_buf(io_addr) &&
    !(setup_lock && (io_addr < USBEP_BUF1_BASE ||
      io_addr >= USBEP_BUF2_BASE));

  // engine writes take the port; a colliding cpu write is dropped
  always_ff @(posedge mclk) begin
    if (eng_buf_we) begin
      buf_mem[eng_buf_idx] <= eng_buf_wdata;
    end else if (cpu_buf_we) begin
      buf_mem[cpu_idx] <= io_wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      eng_buf_rdata <= 8'h00;
    end else begin
      eng_buf_rdata <= buf_mem[eng_buf_idx];
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (io_read_op) begin
      if (is_buf(io_addr)) begin
        io_rdata <= buf_mem[cpu_idx];
      end else begin
        case (io_addr)
          USBEP_OFF_ADDR: io_rdata <= func_addr_reg;
          USBEP_OFF_CNT0: io_rdata <= cnt_reg[0];
          USBEP_OFF_MODE0: io_rdata <= mode0_reg;
          USBEP_OFF_CNT1: io_rdata <= cnt_reg[1];
          USBEP_OFF_MODE1: io_rdata <= mode_reg[1];
          USBEP_OFF_CNT2: io_rdata <= cnt_reg[2];
          USBEP_OFF_MODE2: io_rdata <= mode_reg[2];
          default: io_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      usb_bus_reset <= 1'b0;
    end else begin
      usb_bus_reset <= bus_reset;
    end
  end
endmodule

// [test/usbep_regs_properties.sv]
// port assertions for the endpoint register block
module usbep_regs_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // cpu port
  input wire logic [7:0] io_addr,
  input wire logic io_read_op,
  input wire logic io_write_op,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // engine and line inputs
  input wire logic dp_pin,
  input wire logic dm_pin,
  input wire logic eng_setup_data,
  input wire logic eng_done,
  input wire logic [1:0] eng_ep,
  input wire logic [7:0] token_addr,
  // watched outputs
  input wire logic addr_match,
  input wire logic [3:0] ep0_mode,
  input wire logic [3:0] ep1_tx_count,
  input wire logic usb_bus_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbep_pkg::*;
  localparam int RESET_MIN = 320;
  logic [7:0] addr_reg;
  logic [9:0] se0_cnt;
  logic hit;
  logic rd0;
  logic wr0;
  assign hit = addr_reg[7] && token_addr[6:0] == addr_reg[6:0];
  assign rd0 = io_read_op && io_addr == USBEP_OFF_MODE0;
  assign wr0 = io_write_op && io_addr == USBEP_OFF_MODE0;
  // shadow address; wiped by the pulse, one edge after the design
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) addr_reg <= 8'h00;
    else if (usb_bus_reset) addr_reg <= 8'h00;
    else if (io_write_op && io_addr == USBEP_OFF_ADDR) addr_reg <= io_wdata;
  end
  // raw single-ended zero length, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) se0_cnt <= 10'h000;
    else if (dp_pin || dm_pin) se0_cnt <= 10'h000;
    else if (se0_cnt != 10'h3FF) se0_cnt <= se0_cnt + 10'h001;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_addr_clear: assert property (usb_bus_reset |-> ##2 !addr_match)
    else $error("address match after bus reset");
  a_match_track: assert property (!usb_bus_reset &&
    !$past(usb_bus_reset) |-> addr_match == $past(hit))
    else $error("address match wrong");
  a_mode0_lock: assert property (eng_done && eng_ep == 2'd0
    ##1 (wr0 && !rd0) |=> ##1 $stable(ep0_mode))
    else $error("locked mode write took effect");
  a_setup_read: assert property (eng_setup_data
    ##1 (eng_setup_data && rd0) |=> io_rdata[USBEP_SETUP_BIT])
    else $error("setup flag low during setup data");
  a_count_max: assert property (ep1_tx_count <= USBEP_MAX_COUNT)
    else $error("transmit count above eight");
  a_reset_late: assert property (usb_bus_reset |-> se0_cnt >= RESET_MIN)
    else $error("bus reset too early");
  a_reset_found: assert property (se0_cnt == 10'h12C |->
    ##[1:60] usb_bus_reset)
    else $error("bus reset missed");
  a_reset_pulse: assert property (usb_bus_reset |=> !usb_bus_reset)
    else $error("bus reset not a pulse");
  c_match: cover property (addr_match);
  c_bus_reset: cover property (usb_bus_reset);
  c_ep0_done: cover property (eng_done && eng_ep == 2'd0);
endmodule
bind usbep_regs usbep_regs_props u_usbep_regs_props (.mclk, .reset_n,
  .io_addr, .io_read_op, .io_write_op, .io_wdata, .io_rdata, .dp_pin,
  .dm_pin, .eng_setup_data, .eng_done, .eng_ep, .token_addr, .addr_match,
  .ep0_mode, .ep1_tx_count, .usb_bus_reset);

// [test/usbep_eng_model.sv]
// behavioural serial engine and usb line model
module usbep_eng_model (
  // clock
  input wire logic mclk,
  // status strobes
  output logic eng_setup_data,
  output logic eng_done,
  output usbep_pkg::usbep_tok_t eng_tok,
  output logic [1:0] eng_ep,
  output logic eng_acked,
  output logic eng_valid,
  output logic eng_toggle,
  output logic [7:0] token_addr,
  // buffer port
  output logic eng_buf_we,
  output logic [4:0] eng_buf_idx,
  output logic [7:0] eng_buf_wdata,
  // line levels
  output logic dp_pin,
  output logic dm_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbep_pkg::*;
  initial begin
    {eng_setup_data, eng_done, eng_acked, eng_valid, eng_toggle} = 5'h00;
    {eng_ep, eng_buf_we, eng_buf_idx, eng_buf_wdata} = 16'h0000;
    eng_tok = USBEP_TOK_SETUP;
    token_addr = 8'h00;
    // low-speed idle: minus line high
    dp_pin = 1'b0;
    dm_pin = 1'b1;
  end
  task automatic aim(input logic [7:0] a);
    token_addr <= a;
  endtask
  // status only at the very end of a whole transaction
  task automatic xact(input logic [1:0] ep, input usbep_tok_t tok,
    input logic ack);
    eng_ep <= ep;
    eng_tok <= tok;
    eng_acked <= ack;
    eng_valid <= tok != USBEP_TOK_IN;
    eng_toggle <= 1'b1;
    eng_done <= 1'b1;
    @(posedge mclk);
    eng_done <= 1'b0;
  endtask
  // setup data lands in the control endpoint buffer, flag left high
  task automatic setup_begin();
    eng_setup_data <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      eng_buf_we <= 1'b1;
      eng_buf_idx <= 5'(i);
      eng_buf_wdata <= 8'hA0 + 8'(i);
      @(posedge mclk);
    end
    eng_buf_we <= 1'b0;
    eng_buf_wdata <= ~eng_buf_wdata;
  endtask
  task automatic setup_end();
    eng_setup_data <= 1'b0;
    xact(2'd0, USBEP_TOK_SETUP, 1'b1);
  endtask
  task automatic se0(input logic on);
    dp_pin <= 1'b0;
    dm_pin <= ~on;
  endtask
endmodule

// [test/tb.sv]
// self-checking bench for the endpoint register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import usbep_pkg::*;
  logic mclk, reset_n, io_read_op, io_write_op, eng_setup_data, eng_done;
  logic eng_acked, eng_valid, eng_toggle, dp_pin, dm_pin, eng_buf_we;
  logic addr_match, usb_bus_reset;
  logic [7:0] io_addr, io_wdata, io_rdata, token_addr, eng_buf_wdata;
  logic [3:0] ep0_mode, ep1_mode, ep2_mode;
  logic [3:0] ep0_tx_count, ep1_tx_count, ep2_tx_count;
  logic [1:0] eng_ep;
  logic [4:0] eng_buf_idx;
  usbep_tok_t eng_tok;
  int n_errors = 0;
  int comparisons = 0;
  usbep_regs u_usbep_regs (.mclk, .reset_n, .io_addr, .io_read_op,
    .io_write_op, .io_wdata, .io_rdata, .dp_pin, .dm_pin, .eng_setup_data,
    .eng_done, .eng_tok, .eng_ep, .eng_acked, .eng_valid, .eng_toggle,
    .token_addr, .eng_buf_we, .eng_buf_idx, .eng_buf_wdata,
    .eng_buf_rdata(), .addr_match, .ep0_mode, .ep1_mode, .ep2_mode,
    .ep0_tx_count, .ep1_tx_count, .ep2_tx_count, .usb_bus_reset);
  usbep_eng_model u_usbep_eng_model (.mclk, .eng_setup_data, .eng_done,
    .eng_tok, .eng_ep, .eng_acked, .eng_valid, .eng_toggle, .token_addr,
    .eng_buf_we, .eng_buf_idx, .eng_buf_wdata, .dp_pin, .dm_pin);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle edge after each strobe so no strobe is set twice in a step
  task automatic wr(input logic [7:0] a, d);
    io_addr <= a;
    io_wdata <= d;
    io_write_op <= 1'b1;
    @(posedge mclk);
    io_write_op <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a, exp, input logic [7:0] m = 8'hFF);
    io_addr <= a;
    io_read_op <= 1'b1;
    @(posedge mclk);
    io_read_op <= 1'b0;
    @(posedge mclk);
    chk(io_rdata & m, exp);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    int i;
    {reset_n, io_read_op, io_write_op, io_addr, io_wdata} = 19'h00000;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (i = 16; i <= 22; i++) rc(8'(i), 8'h00);
    $display("test reset values done");
    wr(USBEP_OFF_MODE1, 8'hE3);
    rc(USBEP_OFF_MODE1, 8'h03);
    chk({4'h0, ep1_mode}, 8'h03);
    wr(USBEP_OFF_CNT1, 8'h08);
    wr(USBEP_OFF_CNT2, 8'h05);
    @(posedge mclk);
    chk({4'h0, ep1_tx_count}, 8'h08);
    chk({4'h0, ep2_tx_count}, 8'h05);
    $display("test mode and count done");
    u_usbep_eng_model.aim(8'h05);
    wr(USBEP_OFF_ADDR, 8'h05);
    @(posedge mclk);
    chk({7'h00, addr_match}, 8'h00);
    wr(USBEP_OFF_ADDR, 8'h85);
    @(posedge mclk);
    chk({7'h00, addr_match}, 8'h01);
    rc(USBEP_OFF_ADDR, 8'h85);
    $display("test address done");
    u_usbep_eng_model.xact(2'd1, USBEP_TOK_OUT, 1'b1);
    rc(USBEP_OFF_MODE1, 8'h13);
    rc(USBEP_OFF_CNT1, 8'hC0, 8'hC0);
    u_usbep_eng_model.xact(2'd2, USBEP_TOK_IN, 1'b0);
    rc(USBEP_OFF_MODE2, 8'h00);
    rc(USBEP_OFF_CNT2, 8'h00, 8'hC0);
    $display("test data endpoints done");
    wr(USBEP_OFF_MODE0, 8'h05);
    wr(8'hF8, 8'h22);
    u_usbep_eng_model.setup_begin();
    rc(USBEP_OFF_MODE0, 8'h80, 8'h80);
    wr(8'hF8, 8'h99);
    wr(8'hF0, 8'h33);
    rc(8'hF8, 8'h22);
    rc(8'hF0, 8'h33);
    u_usbep_eng_model.setup_end();
    wr(USBEP_OFF_MODE0, 8'h0A);
    @(posedge mclk);
    chk({4'h0, ep0_mode}, 8'h05);
    rc(USBEP_OFF_MODE0, 8'h95);
    wr(USBEP_OFF_MODE0, 8'h00);
    rc(USBEP_OFF_MODE0, 8'h00);
    rc(8'hE1, 8'hA1);
    wr(8'hF8, 8'h44);
    rc(8'hF8, 8'h44);
    $display("test setup done");
    // token chosen not to match so an early internal clear is harmless
    u_usbep_eng_model.aim(8'h7F);
    u_usbep_eng_model.se0(1'b1);
    for (i = 0; i < 400 && usb_bus_reset !== 1'b1; i++) @(posedge mclk);
    if (i == 400) n_errors++;
    chk({7'h00, i >= 320}, 8'h01);
    u_usbep_eng_model.se0(1'b0);
    repeat (3) @(posedge mclk);
    chk({7'h00, addr_match}, 8'h00);
    rc(USBEP_OFF_ADDR, 8'h00);
    $display("test bus reset done");
    report_and_stop();
  end
endmodule
